// ---- hw/vpic_core.v ----
// vpic_core.v: vectored priority interrupt controller facing the cpu core.
// assumes: single mclk domain, synchronous high reset, peripherals give
// per-cause flags and enables, cpu takes req/level/vector every cycle.
`timescale 1ns/1ps
`include "vpic_map.vh"

module vpic_core #(
  parameter NUM_MASK = 32                       // maskable vector slots
) (
  input  wire                      mclk,          // system clock, 125 MHz
  input  wire                      rst,           // synchronous reset, high
  // fixed exception causes
  input  wire                      rst_cause,     // any reset cause pending
  input  wire                      misalign_req,  // address misaligned exception
  input  wire                      debug_req,     // debug / break request
  input  wire                      wdt_ovf,       // watchdog overflow event
  input  wire                      wdt_nmi_sel,   // 1 = watchdog gives nmi
  // peripheral cause flags and enables
  input  wire                      svd_flag,      // low supply detected
  input  wire                      svd_en,        // its enable
  input  wire                      port_flag,     // port input cause
  input  wire                      port_en,       // its enable
  input  wire [4:0]                clg_flag,      // clock generator causes
  input  wire [4:0]                clg_en,        // their enables
  input  wire [8:0]                rtc_flag,      // real-time clock causes
  input  wire [8:0]                rtc_en,        // their enables
  input  wire [5:0]                t16_flag,      // basic timer underflows, ch 0..5
  input  wire [5:0]                t16_en,        // their enables
  input  wire [13:0]               uart_flag,     // async serial, 7 per channel
  input  wire [13:0]               uart_en,       // their enables
  input  wire [7:0]                spi_flag,      // sync serial, 4 per channel
  input  wire [7:0]                spi_en,        // their enables
  input  wire [15:0]               i2c_flag,      // two-wire bus, 8 per channel
  input  wire [15:0]               i2c_en,        // their enables
  input  wire [15:0]               pwm_flag,      // pwm timers, 4 per channel
  input  wire [15:0]               pwm_en,        // their enables
  input  wire [NUM_MASK-1:0]       ext_req,       // other sources, by vector
  // level programming
  input  wire                      lvl_wr,        // write one source level
  input  wire [4:0]                lvl_sel,       // vector of that source
  input  wire [2:0]                lvl_data,      // new source_priority_level
  input  wire                      base_wr,       // write table base
  input  wire [23:0]               base_data,     // new vector_table_base
  // cpu side
  output reg                       irq,           // interrupt request
  output reg  [2:0]                irq_level,     // level of presented request
  output reg  [4:0]                irq_vector,    // vector number presented
  output reg                       nmi,           // non-maskable request
  output reg                       exc_valid,     // fixed exception present
  output reg  [23:0]               exc_addr,      // handler address to fetch
  output reg  [23:0]               vector_table_base // current table base
);

  // =====================================================================
  // per-vector request lines
  wire [NUM_MASK-1:0] line;
  wire [31:0]         slot_req;

  // vector of each channel, channel 0 in the low five bits; the timer
  // channels do not follow vector order, so one table keeps that mapping
  // and the loops below stay free of special cases
  localparam [29:0] T16_VEC  = {`VPIC_VEC_T16_5, `VPIC_VEC_T16_4, `VPIC_VEC_T16_3,
                                `VPIC_VEC_T16_2, `VPIC_VEC_T16_1, `VPIC_VEC_T16_0};
  localparam [9:0]  UART_VEC = {`VPIC_VEC_UART1, `VPIC_VEC_UART0};
  localparam [9:0]  SPI_VEC  = {`VPIC_VEC_SPI1, `VPIC_VEC_SPI0};
  localparam [9:0]  I2C_VEC  = {`VPIC_VEC_I2C1, `VPIC_VEC_I2C0};

  // each grouped peripheral folds through one gate
  // a registered gate per vector keeps the flag-to-request delay the
  // same for every peripheral source, at the cost of one cycle of latency
  vpic_src_gate #(.NUM_CAUSE(1)) u_svd (
    .mclk       (mclk),
    .rst        (rst),
    .cause_flag (svd_flag),
    .cause_en   (svd_en),
    .src_req    (slot_req[`VPIC_VEC_SVD])
  );
  vpic_src_gate #(.NUM_CAUSE(1)) u_port (
    .mclk       (mclk),
    .rst        (rst),
    .cause_flag (port_flag),
    .cause_en   (port_en),
    .src_req    (slot_req[`VPIC_VEC_PORT])
  );
  vpic_src_gate #(.NUM_CAUSE(5)) u_clg (
    .mclk       (mclk),
    .rst        (rst),
    .cause_flag (clg_flag),
    .cause_en   (clg_en),
    .src_req    (slot_req[`VPIC_VEC_CLG])
  );
  vpic_src_gate #(.NUM_CAUSE(9)) u_rtc (
    .mclk       (mclk),
    .rst        (rst),
    .cause_flag (rtc_flag),
    .cause_en   (rtc_en),
    .src_req    (slot_req[`VPIC_VEC_RTC])
  );

  // repeated channels: one gate per channel, vector taken from the tables, pwm by offset from its first vector
  genvar t;
  genvar c;
  genvar p;
  generate
    // basic timer channel to vector, one underflow each
    for (t = 0; t < 6; t = t + 1) begin : g_t16
      vpic_src_gate #(.NUM_CAUSE(1)) u_tmr (
        .mclk       (mclk),
        .rst        (rst),
        .cause_flag (t16_flag[t]),
        .cause_en   (t16_en[t]),
        .src_req    (slot_req[T16_VEC[5*t +: 5]])
      );
    end

    // async serial channels, seven causes per channel
    for (c = 0; c < 2; c = c + 1) begin : g_uart
      vpic_src_gate #(.NUM_CAUSE(7)) u_ua (
        .mclk       (mclk),
        .rst        (rst),
        .cause_flag (uart_flag[7*c +: 7]),
        .cause_en   (uart_en[7*c +: 7]),
        .src_req    (slot_req[UART_VEC[5*c +: 5]])
      );
    end

    // sync serial channels, four causes per channel
    for (c = 0; c < 2; c = c + 1) begin : g_spi
      vpic_src_gate #(.NUM_CAUSE(4)) u_sp (
        .mclk       (mclk),
        .rst        (rst),
        .cause_flag (spi_flag[4*c +: 4]),
        .cause_en   (spi_en[4*c +: 4]),
        .src_req    (slot_req[SPI_VEC[5*c +: 5]])
      );
    end

    // two-wire bus channels, eight causes per channel
    for (c = 0; c < 2; c = c + 1) begin : g_iic
      vpic_src_gate #(.NUM_CAUSE(8)) u_iic (
        .mclk       (mclk),
        .rst        (rst),
        .cause_flag (i2c_flag[8*c +: 8]),
        .cause_en   (i2c_en[8*c +: 8]),
        .src_req    (slot_req[I2C_VEC[5*c +: 5]])
      );
    end

    // pwm timers 0..3 on consecutive vectors
    for (p = 0; p < 4; p = p + 1) begin : g_pwm
      vpic_src_gate #(.NUM_CAUSE(4)) u_pwm (
        .mclk       (mclk),
        .rst        (rst),
        .cause_flag (pwm_flag[4*p +: 4]),
        .cause_en   (pwm_en[4*p +: 4]),
        .src_req    (slot_req[`VPIC_VEC_PWM0 + p])
      );
    end
  endgenerate

  // vectors 0..3 and 6 carry no maskable hardware source
  // the remaining spare slots take other sources directly
  assign slot_req[3:0] = 4'h0;
  assign slot_req[6]   = 1'b0;
  assign slot_req[23]  = ext_req[23];
  assign slot_req[25]  = ext_req[25];
  assign slot_req[31:27] = ext_req[31:27];
  assign line = slot_req[NUM_MASK-1:0];

  // =====================================================================
  // level table and base register
  reg [2:0] lvl_tab [0:NUM_MASK-1];
  integer   k;

  // one three-bit level per source, all 0 after reset
  always @(posedge mclk) begin
    if (rst) begin
      for (k = 0; k < NUM_MASK; k = k + 1) begin
        lvl_tab[k] <= `VPIC_LVL_RESET;
      end
    end else if (lvl_wr) begin
      lvl_tab[lvl_sel] <= lvl_data;
    end
  end

  // base returns to its default on reset
  // low bits stay zero so the table sits on a 256-byte boundary
  always @(posedge mclk) begin
    if (rst) begin
      vector_table_base <= `VPIC_VECTOR_TABLE_BASE_RESET;
    end else if (base_wr) begin
      vector_table_base <= {base_data[23:`VPIC_VECTOR_TABLE_BASE_ALIGN_BITS],
                            {`VPIC_VECTOR_TABLE_BASE_ALIGN_BITS{1'b0}}};
    end
  end

  // =====================================================================
  // maskable arbitration
  reg [2:0] best_lvl;
  reg [4:0] best_vec;
  reg       best_hit;
  integer   j;

  // scan from high vector down so that a strictly higher
  // level wins and equal levels settle on the smaller vector number;
  // level 0 sources are not presented since the cpu never takes them
  always @* begin
    best_lvl = 3'h0;
    best_vec = 5'h00;
    best_hit = 1'b0;
    for (j = NUM_MASK - 1; j >= 0; j = j - 1) begin
      if (line[j] && lvl_tab[j] != 3'h0 && lvl_tab[j] >= best_lvl) begin
        best_lvl = lvl_tab[j];
        best_vec = j[4:0];
        best_hit = 1'b1;
      end
    end
  end

  // the winner is recomputed every cycle, so a better cause
  // replaces the presented one while losers simply stay pending;
  // a cleared flag drops out of the scan with no interrupt
  always @(posedge mclk) begin
    if (rst) begin
      irq        <= 1'b0;
      irq_level  <= `VPIC_LVL_RESET;
      irq_vector <= 5'h00;
    end else begin
      irq        <= best_hit;
      irq_level  <= best_lvl;
      irq_vector <= best_vec;
    end
  end

  // =====================================================================
  // fixed exceptions
  reg [23:0] next_exc_addr;
  reg        next_exc_valid;
  wire       nmi_cause;

  // watchdog overflow is nmi only when software picked that action
  assign nmi_cause = wdt_ovf & wdt_nmi_sel;

  // table entries at base plus four times the vector
  // reset uses vector 0; watchdog reset rides in rst_cause
  // debug uses its own fixed address, no vector number
  always @* begin
    next_exc_valid = 1'b1;
    next_exc_addr  = vector_table_base;
    if (rst_cause) begin
      next_exc_addr = vector_table_base + `VPIC_VEC_STRIDE * `VPIC_VEC_RESET;
    end else if (misalign_req) begin
      next_exc_addr = vector_table_base + `VPIC_VEC_STRIDE * `VPIC_VEC_MISALIGN;
    end else if (debug_req) begin
      next_exc_addr = `VPIC_DEBUG_ADDR;
    end else if (nmi_cause) begin
      next_exc_addr = vector_table_base + `VPIC_VEC_STRIDE * `VPIC_VEC_NMI;
    end else begin
      next_exc_valid = 1'b0;
    end
  end

  // nmi is passed as its own line since the cpu takes it unconditionally
  always @(posedge mclk) begin
    if (rst) begin
      nmi       <= 1'b0;
      exc_valid <= 1'b0;
      exc_addr  <= `VPIC_VECTOR_TABLE_BASE_RESET;
    end else begin
      nmi       <= nmi_cause & ~rst_cause & ~misalign_req & ~debug_req;
      exc_valid <= next_exc_valid;
      exc_addr  <= next_exc_addr;
    end
  end

endmodule // vpic_core

// ---- hw/vpic_map.vh ----
// vpic_map.vh: constants for the vectored priority interrupt controller.
// assumes: included by bare name from the design files; definitions only.
`ifndef VPIC_MAP_VH
`define VPIC_MAP_VH

// =====================================================================
// vector table layout
`define VPIC_VECTOR_TABLE_BASE_RESET      24'h008000
`define VPIC_VEC_STRIDE      24'h000004
`define VPIC_DEBUG_ADDR      24'hFFFC00
`define VPIC_VECTOR_TABLE_BASE_ALIGN_BITS 8

// =====================================================================
// fixed vector numbers
`define VPIC_VEC_RESET     5'h00
`define VPIC_VEC_MISALIGN  5'h01
`define VPIC_VEC_NMI       5'h02
`define VPIC_VEC_COMPILER  5'h03
`define VPIC_VEC_SVD       5'h04
`define VPIC_VEC_PORT      5'h05
`define VPIC_VEC_RSVD6     5'h06
`define VPIC_VEC_CLG       5'h07
`define VPIC_VEC_RTC       5'h08
`define VPIC_VEC_T16_0     5'h09
`define VPIC_VEC_UART0     5'h0A
`define VPIC_VEC_T16_1     5'h0B
`define VPIC_VEC_SPI0      5'h0C
`define VPIC_VEC_I2C0      5'h0D
`define VPIC_VEC_PWM0      5'h0E
`define VPIC_VEC_PWM3      5'h11
`define VPIC_VEC_T16_5     5'h12
`define VPIC_VEC_UART1     5'h13
`define VPIC_VEC_T16_2     5'h14
`define VPIC_VEC_SPI1      5'h15
`define VPIC_VEC_I2C1      5'h16
`define VPIC_VEC_T16_3     5'h18
`define VPIC_VEC_T16_4     5'h1A

// =====================================================================
// level field
`define VPIC_LVL_W     3
`define VPIC_LVL_RESET 3'h0
`define VPIC_VEC_W     5
`define VPIC_NUM_VEC   32

`endif

// ---- hw/vpic_src_gate.v ----
// vpic_src_gate.v: folds one peripheral's cause flags into one request line.
// assumes: flags and enables are synchronous to mclk and held by the peripheral.
`timescale 1ns/1ps

module vpic_src_gate #(
  parameter NUM_CAUSE = 8                  // cause flags of this peripheral
) (
  input  wire                 mclk,        // system clock
  input  wire                 rst,         // synchronous reset, high
  input  wire [NUM_CAUSE-1:0] cause_flag,  // cause flags
  input  wire [NUM_CAUSE-1:0] cause_en,    // per-cause enables
  output reg                  src_req      // combined request, registered
);

  // =====================================================================
  // request gating
  // any flag that is both set and enabled raises the line
  // enabling an already set flag requests on the next edge, and clearing
  // the flag drops it, which cancels a pending request
  always @(posedge mclk) begin
    if (rst) begin
      src_req <= 1'b0;
    end else begin
      src_req <= |(cause_flag & cause_en);
    end
  end

endmodule // vpic_src_gate

// ---- verif/tb_top.sv ----
// tb_top.sv: self-checking bench for the priority interrupt controller.
// assumes: vpic_core and vpic_cpu_model compiled before, 125 MHz mclk.
`timescale 1ns/1ps

module tb_top;
  reg         mclk, rst, en_all, lvl_wr, base_wr;
  reg  [4:0]  exc_in;    // reset, misalign, debug, watchdog, nmi select
  reg  [19:0] src_on;    // one cause per tested vector
  reg  [4:0]  lvl_sel;
  reg  [2:0]  lvl_data;
  reg  [23:0] base_data;
  wire        irq, nmi, exc_valid;
  wire [2:0]  irq_level;
  wire [4:0]  irq_vector, acc_vec;
  wire [23:0] exc_addr, vector_table_base;
  integer     n_fail, compares;
  // vectors of src_on bits 0..19, lowest in the low bits
  localparam [99:0] VEXP = {5'h1A, 5'h18, 5'h16, 5'h15, 5'h14, 5'h13, 5'h12, 5'h11, 5'h10,
    5'h0F, 5'h0E, 5'h0D, 5'h0C, 5'h0B, 5'h0A, 5'h09, 5'h08, 5'h07, 5'h05, 5'h04};
  vpic_core u_vpic_core (.mclk(mclk), .rst(rst), .rst_cause(exc_in[4]),
    .misalign_req(exc_in[3]), .debug_req(exc_in[2]), .wdt_ovf(exc_in[1]),
    .wdt_nmi_sel(exc_in[0]), .svd_flag(src_on[0]), .svd_en(en_all), .port_flag(src_on[1]),
    .port_en(en_all), .clg_flag({src_on[2], 4'h0}), .clg_en({5{en_all}}),
    .rtc_flag({src_on[3], 8'h00}), .rtc_en({9{en_all}}), .t16_en({6{en_all}}),
    .t16_flag({src_on[13], src_on[19:18], src_on[15], src_on[6], src_on[4]}),
    .uart_flag({src_on[14], 6'h00, src_on[5], 6'h00}), .uart_en({14{en_all}}),
    .spi_flag({src_on[16], 3'h0, src_on[7], 3'h0}), .spi_en({8{en_all}}),
    .i2c_flag({src_on[17], 7'h00, src_on[8], 7'h00}), .i2c_en({16{en_all}}),
    .pwm_flag({2'h0, src_on[12], 3'h0, src_on[11], 3'h0, src_on[10], 3'h0, src_on[9], 1'b0}),
    .pwm_en({16{en_all}}), .ext_req(32'h0), .lvl_wr(lvl_wr), .lvl_sel(lvl_sel),
    .lvl_data(lvl_data), .base_wr(base_wr), .base_data(base_data), .irq(irq),
    .irq_level(irq_level), .irq_vector(irq_vector), .nmi(nmi), .exc_valid(exc_valid),
    .exc_addr(exc_addr), .vector_table_base(vector_table_base));
  vpic_cpu_model u_vpic_cpu_model (.mclk(mclk), .rst(rst), .irq(irq),
    .irq_level(irq_level), .irq_vector(irq_vector), .acc_vec(acc_vec));
  // ====================================================================
  // shared helpers
  task chk(input string what, input [23:0] seen, input [23:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task summarize;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // bounded wait so a stuck request cannot hang the run
  task wait_irq(input v);
    integer k;
    k = 0;
    #1;
    while (irq !== v && k < 20) begin
      @(posedge mclk);
      #1;
      k = k + 1;
    end
    if (irq !== v) begin
      chk("irq wait", {23'h0, irq}, {23'h0, v});
      summarize;
    end
  endtask
  task set_lvl(input [4:0] v, input [2:0] l);
    @(posedge mclk);
    lvl_wr <= 1'b1;
    lvl_sel <= v;
    lvl_data <= l;
    @(posedge mclk);
    lvl_wr <= 1'b0;
  endtask
  task settle(input integer n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // ====================================================================
  // scenarios
  task t_level;
    @(posedge mclk);
    src_on <= 20'h00010;
    settle(4);
    chk("irq at level 0", {23'h0, irq}, 24'h0);
    set_lvl(5'h09, 3'h5);
    settle(4);
    chk("irq disabled", {23'h0, irq}, 24'h0);
    @(posedge mclk);
    en_all <= 1'b1;
    wait_irq(1'b1);
    chk("level", {21'h0, irq_level}, 24'h5);
    chk("vector", {19'h0, irq_vector}, 24'h9);
    set_lvl(5'h09, 3'h0);
    wait_irq(1'b0);
    set_lvl(5'h09, 3'h5);
    wait_irq(1'b1);
    @(posedge mclk);
    src_on <= 20'h0;
    wait_irq(1'b0);
    chk("dropped", {23'h0, irq}, 24'h0);
    chk("cpu took", {19'h0, acc_vec}, 24'h9);
    $display("test level done");
  endtask
  task t_map;
    integer i;
    for (i = 0; i < 20; i = i + 1) begin
      set_lvl(VEXP[5*i +: 5], 3'h3);
      @(posedge mclk);
      src_on <= 20'h1 << i;
      wait_irq(1'b1);
      chk("map vector", {19'h0, irq_vector}, {19'h0, VEXP[5*i +: 5]});
      @(posedge mclk);
      src_on <= 20'h0;
      wait_irq(1'b0);
    end
    $display("test map done");
  endtask
  task t_prio;
    @(posedge mclk);
    src_on <= 20'hFFFFF;
    settle(3);
    chk("tie vector", {19'h0, irq_vector}, 24'h4);
    set_lvl(5'h1A, 3'h7);
    settle(3);
    chk("new vector", {19'h0, irq_vector}, 24'h1A);
    chk("new level", {21'h0, irq_level}, 24'h7);
    @(posedge mclk);
    src_on <= 20'h7FFFF;
    settle(3);
    chk("held vector", {19'h0, irq_vector}, 24'h4);
    @(posedge mclk);
    src_on <= 20'h0;
    wait_irq(1'b0);
    $display("test priority done");
  endtask
  task t_exc;
    integer i;
    @(posedge mclk);
    base_wr <= 1'b1;
    base_data <= 24'h1234AB;
    @(posedge mclk);
    base_wr <= 1'b0;
    settle(2);
    chk("base", vector_table_base, 24'h123400);
    for (i = 0; i < 5; i = i + 1) begin
      @(posedge mclk);
      // reset+misalign, misalign+debug, nmi, debug+nmi, overflow without nmi
      exc_in <= (25'h0238D98 >> (5 * i));
      settle(2);
      chk("exc valid", {23'h0, exc_valid}, {23'h0, i < 4});
      chk("nmi", {23'h0, nmi}, {23'h0, i == 2});
      if (i < 4) chk("exc addr", exc_addr, (i == 3) ? 24'hFFFC00 : 24'h123400 + 4 * i);
    end
    @(posedge mclk);
    exc_in <= 5'h00;
    $display("test exceptions done");
  endtask
  // mid-run reset: base and levels go back to defaults, request drops
  task t_rst;
    @(posedge mclk);
    src_on <= 20'h00001;
    wait_irq(1'b1);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk("base after reset", vector_table_base, 24'h008000);
    chk("irq after reset", {23'h0, irq}, 24'h0);
    settle(4);
    chk("level reset", {23'h0, irq}, 24'h0);
    @(posedge mclk);
    src_on <= 20'h0;
    $display("test reset done");
  endtask
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    rst = 1'b1;
    en_all = 1'b0;
    lvl_wr = 1'b0;
    base_wr = 1'b0;
    exc_in = 5'h00;
    src_on = 20'h0;
    lvl_sel = 5'h00;
    lvl_data = 3'h0;
    base_data = 24'h000000;
    n_fail = 0;
    compares = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk("reset base", vector_table_base, 24'h008000);
    t_level;
    t_map;
    t_prio;
    t_exc;
    t_rst;
    summarize;
  end
endmodule // tb_top

// ---- verif/vpic_core_props.sv ----
// vpic_core_props.sv: assertions on the controller's exception, base and request ports.
// assumes: bound into vpic_core, one mclk domain, synchronous high reset.
`timescale 1ns/1ps

module vpic_core_props (
  input wire        mclk,             // clock
  input wire        rst,              // reset
  input wire        rst_cause,        // reset cause
  input wire        misalign_req,     // misaligned access
  input wire        debug_req,        // break request
  input wire        wdt_ovf,          // watchdog overflow
  input wire        wdt_nmi_sel,      // watchdog gives nmi
  input wire        base_wr,          // base write
  input wire [23:0] base_data,        // new base
  input wire        irq,              // request
  input wire [2:0]  irq_level,        // its level
  input wire [4:0]  irq_vector,       // its vector
  input wire        nmi,              // nmi out
  input wire        exc_valid,        // exception present
  input wire [23:0] exc_addr,         // handler address
  input wire [23:0] vector_table_base // table base
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ====================================================================
  // fixed exception ranking, one step each
  sequence s_mis; !rst_cause && misalign_req; endsequence
  sequence s_dbg; !rst_cause && !misalign_req && debug_req; endsequence
  sequence s_nmi; !rst_cause && !misalign_req && !debug_req && wdt_ovf && wdt_nmi_sel; endsequence
  sequence s_none; !rst_cause && !misalign_req && !debug_req && !(wdt_ovf && wdt_nmi_sel); endsequence
  rst_vec_a: assert property (rst_cause |=> exc_valid && !nmi
    && exc_addr == $past(vector_table_base)) else $error("reset address wrong");
  mis_vec_a: assert property (s_mis |=> exc_valid && !nmi
    && exc_addr == $past(vector_table_base) + 24'h000004) else $error("misalign address wrong");
  dbg_addr_a: assert property (s_dbg |=> exc_valid && !nmi
    && exc_addr == 24'hFFFC00) else $error("debug address wrong");
  nmi_vec_a: assert property (s_nmi |=> exc_valid && nmi
    && exc_addr == $past(vector_table_base) + 24'h000008) else $error("nmi address wrong");
  exc_idle_a: assert property (s_none |=> !exc_valid && !nmi)
    else $error("exception without cause");
  // ====================================================================
  // table base and presented request
  base_wr_a: assert property (base_wr |=> vector_table_base == ($past(base_data) & 24'hFFFF00))
    else $error("base write wrong");
  base_hold_a: assert property (!base_wr |=> $stable(vector_table_base))
    else $error("base changed alone");
  lvl_zero_a: assert property (irq |-> irq_level != 3'h0)
    else $error("level zero presented");
  rsvd_vec_a: assert property (irq |-> irq_vector != 5'h03 && irq_vector != 5'h06)
    else $error("sourceless vector presented");
  cover property (s_nmi);
endmodule // vpic_core_props

bind vpic_core vpic_core_props u_vpic_core_props (.mclk(mclk), .rst(rst),
  .rst_cause(rst_cause), .misalign_req(misalign_req), .debug_req(debug_req),
  .wdt_ovf(wdt_ovf), .wdt_nmi_sel(wdt_nmi_sel), .base_wr(base_wr), .base_data(base_data),
  .irq(irq), .irq_level(irq_level), .irq_vector(irq_vector), .nmi(nmi),
  .exc_valid(exc_valid), .exc_addr(exc_addr), .vector_table_base(vector_table_base));

// ---- verif/vpic_cpu_model.sv ----
// vpic_cpu_model.sv: cpu core as seen from the request, level and vector lines.
// assumes: interrupts enabled, current cpu level 0, samples every cycle.
`timescale 1ns/1ps

module vpic_cpu_model (
  input  wire       mclk,       // clock
  input  wire       rst,        // reset
  input  wire       irq,        // request
  input  wire [2:0] irq_level,  // its level
  input  wire [4:0] irq_vector, // its vector
  output reg  [4:0] acc_vec     // last vector taken
);
  // ====================================================================
  // acceptance: level must beat the cpu level, which stays 0 here
  // level zero refused
  always @(posedge mclk) begin
    if (rst) begin
      acc_vec <= 5'h00;
    end else if (irq && irq_level > 3'h0) begin
      acc_vec <= irq_vector;
    end
  end
endmodule // vpic_cpu_model
